/* File: logic/sdfm_consts.svh */
// constants for the servo drive fault manager
`ifndef SDFM_CONSTS_SVH
`define SDFM_CONSTS_SVH
`define SDFM_CLK_MHZ         100
`define SDFM_REARM_MS        50
`define SDFM_REARM_CYCLES    (`SDFM_REARM_MS * 1000 * `SDFM_CLK_MHZ)
`define SDFM_BLINK_MS        200
`define SDFM_BLINK_CYCLES    (`SDFM_BLINK_MS * 1000 * `SDFM_CLK_MHZ)
`define SDFM_PAUSE_BLINKS    4
`define SDFM_CODE_NONE       5'h00
`define SDFM_CODE_FB_COMM    5'h11
`define SDFM_CODE_WDOG       5'h12
`define SDFM_CODE_POS_ERR    5'h13
`define SDFM_CODE_OPT_CARD   5'h14
`define SDFM_EXT_NONE        2'h0
`define SDFM_EXT_STEP_OVF    2'h1
`define SDFM_EXT_FOLLOW_OVF  2'h2
`define SDFM_EXT_AUX_FB      2'h3
`endif

/* File: logic/sdfm_pkg.sv */
// types for the servo drive fault manager
`default_nettype none
package sdfm_pkg;
	typedef struct packed {
		logic fb_comm_fail;
		logic wdog_timeout;
		logic follow_err_ovf;
		logic step_ovf;
		logic opt_card_aux_fb;
		logic network_sync_lost;
	} sdfm_faults_type;
	typedef enum logic [2:0] {
		SDFM_RUN   = 3'b001,
		SDFM_FAULT = 3'b010,
		SDFM_REARM = 3'b100
	} sdfm_state_type;
endpackage : sdfm_pkg
`default_nettype wire

/* File: logic/sdfm_fault_manager.sv */
// fault sorting, output-stage disable and blink-code display for the servo drive
// Operation
// - on any fault latch latched-class sources, disable output stage, show code on LED
// - non-latched faults re-enable output automatically once condition clears
// - latched faults clear only by enable input disable state or power cycle
// - keep output disabled a further 50 ms rearm delay after self-reset fault
// - with several faults arriving together only highest-priority code is displayed
// - after clear and enable cycle, show highest-priority fault still present
// - feedback link communication failure reports blink code 17
// - option card watchdog timeout reports blink code 18
// - following error or step overflow reports 19, extended code distinguishes
// - option card fault reports 20, extended aux feedback or none
`timescale 1ns/100ps
`default_nettype none
`include "sdfm_consts.svh"
module sdfm_fault_manager
	import sdfm_pkg::*;
#(
	parameter int REARM_CYCLES = `SDFM_REARM_CYCLES,
	parameter int BLINK_CYCLES = `SDFM_BLINK_CYCLES,
	parameter logic [5:0] LATCHED_MASK = 6'b11_1110
) (
	input  wire logic            clk_sys_in,
	input  wire logic            reset_n_in,
	input  wire sdfm_faults_type faults_in,
	input  wire logic            enable_n_in,
	output logic                 output_enable_out,
	output logic                 status_led_out,
	output logic [4:0]           fault_code_out,
	output logic [1:0]           extended_fault_code_out,
	output logic                 fault_active_out
);
	////////////////////////////////////////////////////////////////////////
	// parameter checks; the slot counter is six bits wide
	if (REARM_CYCLES < 1 || BLINK_CYCLES < 2) begin : g_bad_counts
		$error("sdfm: counts too small");
	end
	if (`SDFM_PAUSE_BLINKS < 1 || `SDFM_PAUSE_BLINKS > 11) begin : g_bad_pause
		$error("sdfm: pause does not fit the slot counter");
	end

	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	// every fault and enable pin passes two flops; only the second one is read by logic
	logic [5:0] flt_s1_r;
	logic [5:0] flt_s2_r;
	logic       en_s1_r;
	logic       en_s2_r;
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			flt_s1_r <= 6'h0;
			flt_s2_r <= 6'h0;
			en_s1_r  <= 1'b1;
			en_s2_r  <= 1'b1;
		end else begin
			flt_s1_r <= faults_in;
			flt_s2_r <= flt_s1_r;
			en_s1_r  <= enable_n_in;
			en_s2_r  <= en_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// priority resolution; bit order gives the fixed priority, bit 5 highest
	// sources sharing code 19 or 20 are told apart only by the extended code
	function automatic logic [6:0] sdfm_resolve(input logic [5:0] f);
		sdfm_faults_type s;
		s = f;
		if (s.fb_comm_fail)           sdfm_resolve = {`SDFM_CODE_FB_COMM, `SDFM_EXT_NONE};
		else if (s.wdog_timeout)      sdfm_resolve = {`SDFM_CODE_WDOG, `SDFM_EXT_NONE};
		else if (s.follow_err_ovf)    sdfm_resolve = {`SDFM_CODE_POS_ERR, `SDFM_EXT_FOLLOW_OVF};
		else if (s.step_ovf)          sdfm_resolve = {`SDFM_CODE_POS_ERR, `SDFM_EXT_STEP_OVF};
		else if (s.opt_card_aux_fb)   sdfm_resolve = {`SDFM_CODE_OPT_CARD, `SDFM_EXT_AUX_FB};
		else if (s.network_sync_lost) sdfm_resolve = {`SDFM_CODE_OPT_CARD, `SDFM_EXT_NONE};
		else                          sdfm_resolve = {`SDFM_CODE_NONE, `SDFM_EXT_NONE};
	endfunction : sdfm_resolve

	////////////////////////////////////////////////////////////////////////
	// fault latching and output-stage state
	sdfm_state_type state_r;
	sdfm_state_type state_nxt;
	logic [5:0]     latched_r;
	logic [5:0]     latched_nxt;
	logic [31:0]    rearm_r;
	logic [31:0]    rearm_nxt;
	logic [6:0]     shown_r;
	logic [6:0]     shown_nxt;
	logic           oe_r;
	logic           oe_nxt;
	logic           en_prev_r;
	logic [5:0]     active;
	logic           selfres_now;

	always_comb begin
		// disable state on the enable input wipes latched sources
		if (en_s2_r)
			latched_nxt = 6'h0;
		else
			latched_nxt = latched_r;
		// a latched source still present when the clear comes is caught again
		latched_nxt = latched_nxt | (flt_s2_r & LATCHED_MASK);
		active      = latched_r | flt_s2_r;
		selfres_now = |(flt_s2_r & ~LATCHED_MASK);
		state_nxt   = state_r;
		rearm_nxt   = rearm_r;
		oe_nxt      = 1'b0;
		shown_nxt   = shown_r;
		// a fresh choice only while no code is shown, no source is active, or when the enable input leaves its disable state
		if ((en_prev_r && !en_s2_r) || shown_r[6:2] == `SDFM_CODE_NONE || active == 6'h0)
			shown_nxt = sdfm_resolve(active);
		unique case (state_r)
			SDFM_RUN: begin
				oe_nxt = !en_s2_r;
				if (active != 6'h0) begin
					state_nxt = SDFM_FAULT;
					oe_nxt    = 1'b0;
				end
			end
			SDFM_FAULT: begin
				if (active == 6'h0) begin
					state_nxt = SDFM_REARM;
					rearm_nxt = 32'(REARM_CYCLES - 1);
				end
			end
			// a fault returning during the rearm wait sends it back; the count restarts later
			SDFM_REARM: begin
				if (active != 6'h0)
					state_nxt = SDFM_FAULT;
				else if (rearm_r == 32'h0000_0000)
					state_nxt = SDFM_RUN;
				else
					rearm_nxt = rearm_r - 32'h0000_0001;
			end
		endcase
		if (!selfres_now && !(|latched_r) && active == 6'h0 && state_r == SDFM_FAULT)
			shown_nxt = {`SDFM_CODE_NONE, `SDFM_EXT_NONE};
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state_r   <= SDFM_RUN;
			latched_r <= 6'h0;
			rearm_r   <= 32'h0000_0000;
			shown_r   <= 7'h00;
			oe_r      <= 1'b0;
			en_prev_r <= 1'b1;
		end else begin
			state_r   <= state_nxt;
			latched_r <= latched_nxt;
			rearm_r   <= rearm_nxt;
			shown_r   <= shown_nxt;
			oe_r      <= oe_nxt;
			en_prev_r <= en_s2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// blink engine: code-many on/off pairs, then a pause of dark slots
	// long slots keep a burst readable by eye; a long code with its pause runs for seconds
	logic [31:0] tick_r;
	logic [31:0] tick_nxt;
	logic [5:0]  slot_r;
	logic [5:0]  slot_nxt;
	logic        led_r;
	logic        led_nxt;
	logic [5:0]  slots_total;
	logic [4:0]  code_nxt;

	always_comb begin
		// following the next code keeps the led dark in the very cycle the code clears
		code_nxt    = shown_nxt[6:2];
		slots_total = {code_nxt, 1'b0} + 6'(`SDFM_PAUSE_BLINKS * 2);
		tick_nxt    = tick_r;
		slot_nxt    = slot_r;
		led_nxt     = 1'b0;
		if (code_nxt == `SDFM_CODE_NONE) begin
			tick_nxt = 32'h0000_0000;
			slot_nxt = 6'h00;
		end else begin
			if (tick_r == 32'(BLINK_CYCLES - 1)) begin
				tick_nxt = 32'h0000_0000;
				slot_nxt = (slot_r + 6'h01 >= slots_total) ? 6'h00 : slot_r + 6'h01;
			end else
				tick_nxt = tick_r + 32'h0000_0001;
			// even slots inside the burst light the led
			led_nxt = (slot_nxt < {code_nxt, 1'b0}) && !slot_nxt[0];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			tick_r <= 32'h0000_0000;
			slot_r <= 6'h00;
			led_r  <= 1'b0;
		end else begin
			tick_r <= tick_nxt;
			slot_r <= slot_nxt;
			led_r  <= led_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	// fault_active_out follows the next state so it rises in the cycle the output enable drops for a fault
	logic fa_r;
	logic fa_nxt;
	always_comb begin
		fa_nxt = (state_nxt != SDFM_RUN);
	end
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in)
			fa_r <= 1'b0;
		else
			fa_r <= fa_nxt;
	end
	assign output_enable_out       = oe_r;
	assign status_led_out          = led_r;
	assign fault_code_out          = shown_r[6:2];
	assign extended_fault_code_out = shown_r[1:0];
	assign fault_active_out        = fa_r;
endmodule : sdfm_fault_manager
`default_nettype wire

/* File: tb/sdfm_checker.sv */
// port assertions for the fault manager
`timescale 1ns/100ps
`default_nettype none
module sdfm_checker
	import sdfm_pkg::*;
#(
	parameter int REARM_CYCLES = 20
) (
	input wire logic            clk_sys_in,
	input wire logic            reset_n_in,
	input wire sdfm_faults_type faults_in,
	input wire logic            enable_n_in,
	input wire logic            output_enable_out,
	input wire logic            status_led_out,
	input wire logic [4:0]      fault_code_out,
	input wire logic [1:0]      extended_fault_code_out,
	input wire logic            fault_active_out
);
	// two sync flops and one output register sit ahead of every output
	localparam int RA = REARM_CYCLES + 3;
	localparam int RB = REARM_CYCLES + 10;
	function automatic logic [6:0] want(input logic [5:0] f);
		return f[5] ? 7'h44 : f[4] ? 7'h48 : f[3] ? 7'h4e : f[2] ? 7'h4d : f[1] ? 7'h53 : 7'h50;
	endfunction : want
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	a_code_map: assert property (faults_in != 0 && $past(faults_in) == 0 && !fault_active_out
		|-> ##4 {fault_code_out, extended_fault_code_out} == want(faults_in)) else $error("wrong fault code");
	a_fault_off: assert property (faults_in != 0 |-> ##4 !output_enable_out) else $error("stage left on");
	a_enable_off: assert property (enable_n_in |-> ##4 !output_enable_out) else $error("enable ignored");
	a_latch_hold: assert property ((!enable_n_in)[*4] ##0 fault_code_out == 5'h11 |=> fault_active_out)
		else $error("latch lost");
	a_rearm_hold: assert property ($fell(faults_in.network_sync_lost) && faults_in == 0 && !enable_n_in
		|-> ##RA !output_enable_out) else $error("rearm too short");
	a_auto_on: assert property ($fell(faults_in.network_sync_lost) && faults_in == 0 && !enable_n_in
		|-> ##[1:RB] output_enable_out) else $error("no auto restart");
	a_idle_dark: assert property (fault_code_out == 0 |-> !status_led_out) else $error("led lit idle");
	a_on_in_run: assert property (output_enable_out |-> !fault_active_out && fault_code_out == 0)
		else $error("stage on in fault");
	c_code_19: cover property (fault_code_out == 5'h13);
	c_restart: cover property ($fell(fault_active_out));
	c_led_on: cover property (status_led_out);
endmodule : sdfm_checker
bind sdfm_fault_manager sdfm_checker #(.REARM_CYCLES(REARM_CYCLES)) i_chk (.clk_sys_in(clk_sys_in),
	.reset_n_in(reset_n_in), .faults_in(faults_in), .enable_n_in(enable_n_in), .output_enable_out(output_enable_out),
	.status_led_out(status_led_out), .fault_code_out(fault_code_out),
	.extended_fault_code_out(extended_fault_code_out), .fault_active_out(fault_active_out));
`default_nettype wire

/* File: tb/sdfm_far_side.sv */
// far side: protection circuits, enable switch and led watcher
`timescale 1ns/100ps
`default_nettype none
module sdfm_far_side
	import sdfm_pkg::*;
(
	input  wire logic          clk_sys_in,
	input  wire logic          status_led_in,
	output var sdfm_faults_type faults_out,
	output var logic           enable_n_out
);
	logic led_q = 1'b0;
	int   blinks = 0;
	initial begin
		faults_out = '0;
		enable_n_out = 1'b0;
	end
	task automatic set(input logic [5:0] f, input logic en_n);
		@(posedge clk_sys_in);
		faults_out <= f;
		enable_n_out <= en_n;
	endtask : set
	// counts led rises so a whole burst can be compared
	always @(posedge clk_sys_in) begin
		led_q <= status_led_in;
		if (status_led_in && !led_q) blinks <= blinks + 1;
	end
endmodule : sdfm_far_side
`default_nettype wire

/* File: tb/servo_drive_fault_manager_tb_top.sv */
// self-checking bench for the fault manager
`timescale 1ns/100ps
`default_nettype none
module servo_drive_fault_manager_tb_top
	import sdfm_pkg::*;
;
	localparam int RA = 20;
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	sdfm_faults_type faults;
	logic en_n, oe, led, act;
	logic [4:0] code;
	logic [1:0] ext;
	int fail_count = 0;
	int num_checks = 0;
	int b0;
	logic [5:0] pat [5] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02};
	logic [6:0] want [5] = '{7'h44, 7'h48, 7'h4e, 7'h4d, 7'h53};
	initial forever #5 clk_sys_in = ~clk_sys_in;
	sdfm_fault_manager #(.REARM_CYCLES(RA), .BLINK_CYCLES(4)) i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.faults_in(faults), .enable_n_in(en_n), .output_enable_out(oe), .status_led_out(led),
		.fault_code_out(code), .extended_fault_code_out(ext), .fault_active_out(act));
	sdfm_far_side i_far (.clk_sys_in(clk_sys_in), .status_led_in(led), .faults_out(faults), .enable_n_out(en_n));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : w
	// enable pulse long enough to pass the input synchroniser; the rearm wait follows latched faults too
	task automatic cycle_en(input logic [5:0] f);
		i_far.set(f, 1'b1);
		w(6);
		i_far.set(f, 1'b0);
		w(RA + 8);
	endtask : cycle_en
	initial begin
		w(2);
		reset_n_in <= 1'b1;
		w(8);
		chk(oe, 1);
		for (int i = 0; i < 5; i++) begin
			i_far.set(pat[i], 1'b0);
			w(6);
			chk({oe, code, ext}, {1'b0, want[i]});
			b0 = i_far.blinks;
			w((2 * want[i][6:2] + 8) * 4);
			chk(i_far.blinks - b0, want[i][6:2]);
			i_far.set(6'h00, 1'b0);
			w(8);
			chk({oe, act}, 2'b01);
			cycle_en(6'h00);
			chk({oe, code}, 6'h20);
		end
		i_far.set(6'h01, 1'b0);
		w(6);
		chk({oe, code, ext}, 8'h50);
		i_far.set(6'h00, 1'b0);
		w(RA + 4);
		chk(oe, 0);
		w(1);
		chk(oe, 1);
		i_far.set(6'h30, 1'b0);
		w(6);
		chk(code, 5'h11);
		i_far.set(6'h10, 1'b0);
		cycle_en(6'h10);
		chk({oe, code}, 6'h12);
		summarize();
	end
	initial begin
		#100us;
		fail_count++;
		summarize();
	end
endmodule : servo_drive_fault_manager_tb_top
`default_nettype wire
